// File: rtl/flash_security_option_loader.v
/*
 flash_security_option_loader: working option and protection registers
 reloaded from flash at every reset, backdoor key gate and security state,
 reached over an axi4-lite slave.
 assumes a flash array read port and a tag telling whether the current bus
 master is code from secure memory or the background debug interface.
*/
// The AXI4-Lite register port was chosen for this implementation.
// Summary of operation
// [R1] every reset reloads the working protection and option registers from their nonvolatile bytes.
// [R2] the backdoor key may unlock security only while the key enable bit reads one.
// [R3] key entry is taken only from code running in secure memory, all else is refused.
// [R4] the background debug interface can never present the key.
// [R5] a key enable of zero disables key comparison entirely.
// [R6] with the key disabled, security lifts only after a mass erase then a passing blank check.
// [R7] the two security bits mean unsecured only for pattern 1:0, secured otherwise.
// [R8] software must write the reserved bit of the low voltage control register as zero.
// [R9] while secured, ram access from debug or non-secure code is blocked.
// [R10] flash command code 05 hex is blank check and 41 hex is mass erase.
// [R11] a key match unlocks only until the next reset, a mismatch leaves the part secured.
`timescale 1ns/1ps
`include "flash_security_regs.vh"
module flash_security_option_loader #(
   parameter KEY_WIDTH = 64
) (
   // clock and reset
   input wire clock,
   input wire rst,
   // axi4-lite write address
   input wire [17:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [17:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // access source of the current bus master
   input wire from_secure_code,
   input wire from_debug,
   // flash array read port
   output wire [15:0] nv_addr,
   input wire [7:0] nv_data,
   // flash controller status
   input wire erase_done,
   input wire blank_ok,
   // ram gate
   input wire ram_req,
   input wire ram_from_debug,
   input wire ram_from_nonsecure,
   output wire ram_grant,
   // status to the chip
   output wire secured,
   output wire load_done,
   output wire [7:0] working_protection_reg,
   output wire [7:0] working_option_reg
);
   reg [7:0] prot_r;
   reg [7:0] opt_r;
   reg [7:0] cfg_r;
   reg [7:0] cmd_r;
   reg [7:0] lvc_r;
   reg [KEY_WIDTH-1:0] stored_key_r;
   reg [KEY_WIDTH-1:0] entered_key_r;
   reg key_unlock_r;
   reg erase_seen_r;
   reg erase_unlock_r;
   reg key_refused_r;
   reg compare_req_r;
   reg aw_held_r;
   reg w_held_r;
   reg [15:0] aw_idx_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   wire byte_valid;
   wire [3:0] byte_index;
   wire [7:0] byte_data;
   wire key_match;
   wire key_mismatch;
   wire [1:0] sec_field;
   wire key_enabled;
   wire key_source_ok;
   wire wr_fire;
   wire [15:0] ar_idx;
   reg wr_err;
   reg [31:0] rd_word;
   reg rd_err;

   nv_loader u_loader (
      .clock(clock),
      .rst(rst),
      .nv_addr(nv_addr),
      .nv_data(nv_data),
      .byte_valid(byte_valid),
      .byte_index(byte_index),
      .byte_data(byte_data),
      .done(load_done)
   );

   key_compare #(.KEY_WIDTH(KEY_WIDTH)) u_compare (
      .clock(clock),
      .rst(rst),
      .compare_req(compare_req_r),
      .entered_key(entered_key_r),
      .stored_key(stored_key_r),
      .match(key_match),
      .mismatch(key_mismatch)
   );

   // security decode, only 1:0 means unsecured
   assign sec_field = {opt_r[`OPT_SEC_HI], opt_r[`OPT_SEC_LO]};
   assign secured = !load_done || ((sec_field != `SEC_UNSECURED) && !key_unlock_r && !erase_unlock_r); // [R7]
   assign key_enabled = opt_r[`OPT_KEY_ENABLE]; // [R2] [R5]
   // only secure code with key access selected, never debug
   assign key_source_ok = from_secure_code && !from_debug && cfg_r[`CFG_KEY_ACCESS]; // [R3] [R4]
   // ram blocked for debug and non-secure code while secured
   assign ram_grant = ram_req && !(secured && (ram_from_debug || ram_from_nonsecure)); // [R9]
   assign working_protection_reg = prot_r;
   assign working_option_reg = opt_r;

   // write channel: address and data accepted in either order
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;
   assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign ar_idx = s_axi_araddr[17:2];

   // write address decode
   always @* begin
      case (aw_idx_r)
         `IDX_WORKING_OPTION, `IDX_FLASH_CONFIG, `IDX_WORKING_PROTECT, `IDX_FLASH_COMMAND,
         `IDX_KEY_ENTRY_LO, `IDX_KEY_ENTRY_HI, `IDX_SEC_STATUS, `IDX_LOW_VOLTAGE_CTRL: wr_err = 1'b0;
         default: wr_err = 1'b1;
      endcase
   end

   // read mux, narrow registers in the low bits
   always @* begin
      rd_err = 1'b0;
      case (ar_idx)
         `IDX_WORKING_OPTION: rd_word = {24'h000000, opt_r};
         `IDX_FLASH_CONFIG: rd_word = {24'h000000, cfg_r & `CFG_WRITE_MASK};
         `IDX_WORKING_PROTECT: rd_word = {24'h000000, prot_r};
         `IDX_FLASH_COMMAND: rd_word = {24'h000000, cmd_r};
         `IDX_LOW_VOLTAGE_CTRL: rd_word = {24'h000000, lvc_r};
         // the entered key is write-only so it cannot be read back by untrusted code
         `IDX_KEY_ENTRY_LO: rd_word = 32'h00000000;
         `IDX_KEY_ENTRY_HI: rd_word = 32'h00000000;
         `IDX_SEC_STATUS: rd_word = {26'h0000000, key_refused_r, erase_unlock_r, key_unlock_r,
                                     load_done, secured, key_enabled};
         default: begin
            rd_word = 32'h00000000;
            rd_err = 1'b1;
         end
      endcase
   end

   // bus handshake and write response
   always @(posedge clock) begin
      if (rst) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_idx_r <= 16'h0000;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `AXI_OKAY;
         s_axi_rdata <= 32'h00000000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_idx_r <= s_axi_awaddr[17:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? `AXI_SLVERR : `AXI_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_err ? `AXI_SLVERR : `AXI_OKAY;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // register file, reload from flash and the security state machine
   always @(posedge clock) begin
      if (rst) begin
         // secure defaults until the nonvolatile bytes arrive
         prot_r <= 8'h00;
         opt_r <= {6'h00, `SEC_FORCE_SECURE};
         cfg_r <= 8'h00;
         cmd_r <= 8'h00;
         lvc_r <= 8'h00;
         stored_key_r <= {KEY_WIDTH{1'b0}};
         entered_key_r <= {KEY_WIDTH{1'b0}};
         key_unlock_r <= 1'b0; // [R11]
         erase_seen_r <= 1'b0;
         erase_unlock_r <= 1'b0;
         key_refused_r <= 1'b0;
         compare_req_r <= 1'b0;
      end else begin
         compare_req_r <= 1'b0;
         // reload of the nonvolatile bytes after every reset
         if (byte_valid) begin
            if (byte_index < 4'h8)
               stored_key_r[byte_index*8 +: 8] <= byte_data;
            else if (byte_index == 4'h8)
               prot_r <= byte_data; // [R1]
            else
               opt_r <= byte_data; // [R1]
         end
         if (wr_fire && !wr_err && wstrb_r[0]) begin
            case (aw_idx_r)
               `IDX_FLASH_CONFIG: cfg_r <= wdata_r[7:0] & `CFG_WRITE_MASK;
               `IDX_WORKING_PROTECT: prot_r <= wdata_r[7:0];
               `IDX_FLASH_COMMAND: cmd_r <= wdata_r[7:0];
               // reserved bit forced low in case software breaks its side
               `IDX_LOW_VOLTAGE_CTRL: lvc_r <= wdata_r[7:0] & `LVC_WRITE_MASK; // [R8]
               `IDX_KEY_ENTRY_LO: begin
                  if (key_source_ok && load_done)
                     entered_key_r[31:0] <= wdata_r; // [R3]
                  else
                     key_refused_r <= 1'b1; // [R3] [R4]
               end
               `IDX_KEY_ENTRY_HI: begin
                  // high word triggers the compare, only with key enabled
                  if (key_source_ok && key_enabled && load_done) begin
                     entered_key_r[KEY_WIDTH-1:32] <= wdata_r[KEY_WIDTH-33:0];
                     compare_req_r <= 1'b1; // [R2]
                  end else begin
                     key_refused_r <= 1'b1; // [R5]
                  end
               end
               // write one to clear the refused flag
               `IDX_SEC_STATUS: if (wdata_r[5]) key_refused_r <= 1'b0;
               default: ;
            endcase
         end
         // match lifts security until next reset, mismatch leaves it set
         if (key_match && key_enabled)
            key_unlock_r <= 1'b1; // [R11] [R2]
         // mass erase then blank check, the path left when the key is off
         if (erase_done && cmd_r == `CMD_MASS_ERASE)
            erase_seen_r <= 1'b1; // [R10] [R6]
         if (blank_ok && cmd_r == `CMD_BLANK_CHECK && erase_seen_r)
            erase_unlock_r <= 1'b1; // [R10] [R6]
         // late refusal set wins over a same-cycle clear
         if (key_mismatch)
            key_refused_r <= 1'b1; // [R11]
      end
   end
endmodule // flash_security_option_loader

// File: rtl/flash_security_regs.vh
/*
 flash security option loader: register offsets, field positions, codes.
 assumes inclusion by bare name from rtl/ modules.
*/
`ifndef FLASH_SECURITY_REGS_VH
`define FLASH_SECURITY_REGS_VH
// printed offsets are not multiples of four: kept as indices, byte address = 4 * index
`define IDX_WORKING_OPTION 16'h1821
`define IDX_FLASH_CONFIG 16'h1823
`define IDX_WORKING_PROTECT 16'h1824
`define IDX_FLASH_COMMAND 16'h1826
`define IDX_KEY_ENTRY_LO 16'h1828
`define IDX_KEY_ENTRY_HI 16'h1829
`define IDX_SEC_STATUS 16'h182a
`define IDX_LOW_VOLTAGE_CTRL 16'h1809
// nonvolatile byte offsets in the flash array
`define NV_KEY_BASE 16'hffb0
`define NV_PROTECT 16'hffbd
`define NV_OPTION 16'hffbf
// option byte fields
`define OPT_KEY_ENABLE 7
`define OPT_SEC_HI 1
`define OPT_SEC_LO 0
`define OPT_WRITE_MASK 8'hc3
// configuration fields
`define CFG_KEY_ACCESS 5
`define CFG_WRITE_MASK 8'h20
// low voltage control reserved bit position, software writes it as zero
`define LVC_RESERVED_BIT 1
`define LVC_WRITE_MASK 8'hfd
// security encodings
`define SEC_UNSECURED 2'h2
`define SEC_FORCE_SECURE 2'h3
// flash commands
`define CMD_BLANK_CHECK 8'h05
`define CMD_MASS_ERASE 8'h41
// load sequence length: key bytes plus two option bytes
`define LOAD_STEPS 4'ha
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// File: rtl/nv_loader.v
/*
 nv_loader: after reset, walks the nonvolatile bytes out of the flash array
 one read a cycle and hands each byte with its step index to the caller.
 assumes the flash array returns read data on the cycle after the address.
*/
`timescale 1ns/1ps
`include "flash_security_regs.vh"
module nv_loader (
   // clock and reset
   input wire clock,
   input wire rst,
   // flash read port
   output reg [15:0] nv_addr,
   input wire [7:0] nv_data,
   // captured byte
   output reg byte_valid,
   output reg [3:0] byte_index,
   output reg [7:0] byte_data,
   output reg done
);
   reg [3:0] step_r;
   reg issued_r;
   reg [3:0] last_r;

   // address for each step: eight key bytes, protection, option
   always @* begin
      if (step_r < 4'h8)
         nv_addr = `NV_KEY_BASE + {12'h000, step_r};
      else if (step_r == 4'h8)
         nv_addr = `NV_PROTECT;
      else
         nv_addr = `NV_OPTION;
   end

   // one byte per cycle, data seen a cycle after its address
   always @(posedge clock) begin
      if (rst) begin
         step_r <= 4'h0;
         issued_r <= 1'b0;
         last_r <= 4'h0;
         byte_valid <= 1'b0;
         byte_index <= 4'h0;
         byte_data <= 8'h00;
         done <= 1'b0;
      end else begin
         byte_valid <= issued_r;
         byte_index <= last_r;
         byte_data <= nv_data;
         // done rises the cycle after the last byte is handed over, so the option byte is in place when it is seen
         if (byte_valid && byte_index == `LOAD_STEPS - 4'h1)
            done <= 1'b1;
         if (step_r != `LOAD_STEPS) begin
            issued_r <= 1'b1;
            last_r <= step_r;
            step_r <= step_r + 4'h1;
         end else begin
            issued_r <= 1'b0;
         end
      end
   end
endmodule // nv_loader

// File: rtl/key_compare.v
/*
 key_compare: compares a software-entered 64-bit key with the stored
 backdoor key and reports a one-cycle match or mismatch pulse.
 assumes both keys are stable while compare_req is high.
*/
`timescale 1ns/1ps
module key_compare #(
   parameter KEY_WIDTH = 64
) (
   // clock and reset
   input wire clock,
   input wire rst,
   // request
   input wire compare_req,
   input wire [KEY_WIDTH-1:0] entered_key,
   input wire [KEY_WIDTH-1:0] stored_key,
   // result
   output reg match,
   output reg mismatch
);
   wire [KEY_WIDTH-1:0] diff;
   genvar i;

   // per-bit difference
   generate
      for (i = 0; i < KEY_WIDTH; i = i + 1) begin : g_bit
         assign diff[i] = entered_key[i] ^ stored_key[i];
      end
   endgenerate

   // registered verdict
   always @(posedge clock) begin
      if (rst) begin
         match <= 1'b0;
         mismatch <= 1'b0;
      end else begin
         match <= compare_req && (diff == {KEY_WIDTH{1'b0}});
         mismatch <= compare_req && (diff != {KEY_WIDTH{1'b0}});
      end
   end
endmodule // key_compare

// File: verif/flash_security_properties.sv
/*
 flash_security_checker: port-level properties of the security option block.
 assumes bind onto flash_security_option_loader, one clock, sync reset.
*/
`timescale 1ns/1ps
module flash_security_checker (
   // clock and reset
   input logic clock,
   input logic rst,
   // bus handshakes
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   // flash status and ram gate
   input logic blank_ok,
   input logic ram_req,
   input logic ram_from_debug,
   input logic ram_from_nonsecure,
   input logic ram_grant,
   // security status
   input logic secured,
   input logic load_done,
   input logic [7:0] working_option_reg
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // multi-step causes
   sequence both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // blank check pass seen shortly before, the only legal unlock without key
   sequence blank_recent;
      $past(blank_ok) || $past(blank_ok, 2) || $past(blank_ok, 3) || $past(blank_ok, 4);
   endsequence
   a_write_answer: assert property (both_taken |-> ##2 s_axi_bvalid) else $error("write answer late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (ar_taken |=> s_axi_rvalid) else $error("read answer late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_load_bound: assert property ($fell(rst) |-> ##[0:20] load_done) else $error("reload never ends");
   a_secure_decode: assert property ($rose(load_done) |-> secured == (working_option_reg[1:0] != 2'h2))
      else $error("security decode wrong");
   a_locked_till_load: assert property ($past(rst) |-> secured && !load_done) else $error("open before reload");
   a_ram_blocked: assert property (secured && ram_req && (ram_from_debug || ram_from_nonsecure) |-> !ram_grant)
      else $error("ram open while secured");
   a_erase_unlock: assert property ($fell(secured) && $past(load_done) && !working_option_reg[7] |-> blank_recent)
      else $error("unlock without blank check");
endmodule // flash_security_checker
bind flash_security_option_loader flash_security_checker chk_u (.clock, .rst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .blank_ok, .ram_req, .ram_from_debug, .ram_from_nonsecure,
   .ram_grant, .secured, .load_done, .working_option_reg);

// File: verif/tb.sv
/*
 tb: self-checking bench for the security option block, flash array modelled inline.
 assumes the flash answers one cycle after the address.
*/
`timescale 1ns/1ps
`include "flash_security_regs.vh"
module tb;
   logic clock, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic from_secure_code, from_debug, erase_done, blank_ok, ram_req, ram_from_debug, ram_from_nonsecure;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, rd, rnd;
   logic [3:0] s_axi_wstrb;
   logic [7:0] nv_data, nv_prot, nv_opt;
   logic [63:0] key;
   logic [1:0] rr;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ram_grant, secured, load_done;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [15:0] nv_addr;
   wire [7:0] working_protection_reg, working_option_reg;
   integer seed, err_count, num_checks, cyc, i;
   flash_security_option_loader dut_u (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .from_secure_code,
      .from_debug, .nv_addr, .nv_data, .erase_done, .blank_ok, .ram_req, .ram_from_debug, .ram_from_nonsecure,
      .ram_grant, .secured, .load_done, .working_protection_reg, .working_option_reg);
   initial begin
      clock = 0;
      forever #10 clock = ~clock;
   end
   // flash array: key bytes, protection and option bytes, erased elsewhere
   always @(posedge clock) begin
      nv_data <= ((nv_addr & 16'hfff8) == `NV_KEY_BASE) ? key[nv_addr[2:0]*8 +: 8] :
         (nv_addr == `NV_PROTECT) ? nv_prot : (nv_addr == `NV_OPTION) ? nv_opt : 8'hff;
   end
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         give_verdict;
      end
   end
   task give_verdict;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [15:0] idx, input logic [31:0] d);
      @(posedge clock);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1);
      rr = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task rd_reg(input logic [15:0] idx);
      @(posedge clock);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   // reset with given flash bytes, then wait for the reload
   task do_reset(input logic [7:0] p, input logic [7:0] o);
      nv_prot = p;
      nv_opt = o;
      @(posedge clock);
      rst <= 1;
      repeat (2) @(posedge clock);
      rst <= 0;
      for (int k = 0; k < 40 && load_done !== 1; k++) @(posedge clock);
      chk(working_option_reg, o);
      chk(working_protection_reg, p);
      chk(secured, o[1:0] != 2'h2);
   endtask
   task try_key(input logic [63:0] k, input logic s, input logic d, input logic exp);
      from_secure_code <= s;
      from_debug <= d;
      wr(`IDX_KEY_ENTRY_LO, k[31:0]);
      wr(`IDX_KEY_ENTRY_HI, k[63:32]);
      repeat (4) @(posedge clock);
      chk(secured, exp);
   endtask
   task ram_try(input logic dbg, input logic ns, input logic exp);
      ram_req <= 1;
      ram_from_debug <= dbg;
      ram_from_nonsecure <= ns;
      @(posedge clock);
      @(posedge clock);
      chk(ram_grant, exp);
      ram_req <= 0;
      @(posedge clock);
   endtask
   initial begin
      {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h21;
      {from_secure_code, from_debug, erase_done, blank_ok, ram_req, ram_from_debug, ram_from_nonsecure} = 7'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 68'h0;
      s_axi_wstrb = 4'hf;
      {err_count, num_checks, cyc} = 96'h0;
      seed = 32'hd61a06b3;
      key = {$random(seed), $random(seed)};
      // every security pattern, key disabled
      for (i = 0; i < 4; i++) do_reset(8'($random(seed)), {6'h00, i[1:0]});
      do_reset(8'($random(seed)), 8'h83);
      wr(`IDX_FLASH_CONFIG, 32'h20);
      try_key(key ^ 64'h1, 1, 0, 1);
      rd_reg(`IDX_SEC_STATUS);
      chk(rd[5], 1);
      try_key(key, 1, 1, 1);
      try_key(key, 0, 0, 1);
      ram_try(1, 0, 0);
      ram_try(0, 1, 0);
      ram_try(0, 0, 1);
      try_key(key, 1, 0, 0);
      ram_try(1, 1, 1);
      do_reset(8'h5a, 8'h83);
      do_reset(8'ha5, 8'h03);
      wr(`IDX_FLASH_CONFIG, 32'h20);
      try_key(key, 1, 0, 1);
      // blank check alone must not open a part that was never erased
      wr(`IDX_FLASH_COMMAND, `CMD_BLANK_CHECK);
      blank_ok <= 1;
      @(posedge clock);
      blank_ok <= 0;
      repeat (4) @(posedge clock);
      chk(secured, 1);
      wr(`IDX_FLASH_COMMAND, `CMD_MASS_ERASE);
      erase_done <= 1;
      @(posedge clock);
      erase_done <= 0;
      wr(`IDX_FLASH_COMMAND, `CMD_BLANK_CHECK);
      blank_ok <= 1;
      @(posedge clock);
      blank_ok <= 0;
      repeat (4) @(posedge clock);
      chk(secured, 0);
      rnd = $random(seed);
      wr(`IDX_WORKING_PROTECT, rnd);
      rd_reg(`IDX_WORKING_PROTECT);
      chk(rd, {24'h0, rnd[7:0]});
      wr(`IDX_WORKING_OPTION, 32'h7c);
      rd_reg(`IDX_WORKING_OPTION);
      chk(rd, 32'h03);
      wr(16'h1822, rnd);
      chk(rr, `AXI_SLVERR);
      rd_reg(16'h1822);
      chk(rd, 32'h0);
      chk(rr, `AXI_SLVERR);
      wr(`IDX_LOW_VOLTAGE_CTRL, rnd & `LVC_WRITE_MASK);
      chk(rr, `AXI_OKAY);
      rd_reg(`IDX_LOW_VOLTAGE_CTRL);
      chk(rd, {24'h0, rnd[7:0] & `LVC_WRITE_MASK});
      give_verdict;
   end
endmodule // tb
